/* rtl/msfr_pkg.sv */
/*
  Constants of the core register bank and digital I/O port block:
  register offsets, reset values, field positions.
  Assumes a byte-wide register port driven by the core on clk_in.
*/
package msfr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_PORT0   = 8'h80;
  localparam logic [7:0] OFS_SP      = 8'h81;
  localparam logic [7:0] OFS_DPL0    = 8'h82;
  localparam logic [7:0] OFS_DPH0    = 8'h83;
  localparam logic [7:0] OFS_DATA_POINTER_LOW_SECOND    = 8'h84;
  localparam logic [7:0] OFS_DATA_POINTER_HIGH_SECOND    = 8'h85;
  localparam logic [7:0] OFS_UARTSPD = 8'h87;
  localparam logic [7:0] OFS_TCTL    = 8'h88;
  localparam logic [7:0] OFS_TMODE   = 8'h89;
  localparam logic [7:0] OFS_TL0     = 8'h8A;
  localparam logic [7:0] OFS_TL1     = 8'h8B;
  localparam logic [7:0] OFS_TH0     = 8'h8C;
  localparam logic [7:0] OFS_TH1     = 8'h8D;
  localparam logic [7:0] OFS_STRETCH = 8'h8E;
  localparam logic [7:0] OFS_PORT1   = 8'h90;
  localparam logic [7:0] OFS_PSEL    = 8'h92;
  localparam logic [7:0] OFS_S0CTL   = 8'h98;
  localparam logic [7:0] OFS_SERIAL_ZERO_BUFFER   = 8'h99;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE_TWO    = 8'h9A;
  localparam logic [7:0] OFS_S1CTL   = 8'h9B;
  localparam logic [7:0] OFS_SERIAL_ONE_BUFFER   = 8'h9C;
  localparam logic [7:0] OFS_S1RLL   = 8'h9D;
  localparam logic [7:0] OFS_PORT2   = 8'hA0;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE_ZERO    = 8'hA8;
  localparam logic [7:0] OFS_IP0     = 8'hA9;
  localparam logic [7:0] OFS_S0RLL   = 8'hAA;
  localparam logic [7:0] OFS_PORT3   = 8'hB0;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE_ONE    = 8'hB8;
  localparam logic [7:0] OFS_IP1     = 8'hB9;
  localparam logic [7:0] OFS_S0RLH   = 8'hBA;
  localparam logic [7:0] OFS_S1RLH   = 8'hBB;
  localparam logic [7:0] OFS_PAGEHI  = 8'hBF;
  localparam logic [7:0] OFS_IRQCTL  = 8'hC0;
  localparam logic [7:0] OFS_EXTPOL  = 8'hC8;
  localparam logic [7:0] OFS_PSW     = 8'hD0;
  localparam logic [7:0] OFS_BAUD    = 8'hD8;
  localparam logic [7:0] OFS_ACC     = 8'hE0;
  localparam logic [7:0] OFS_MDOP    = 8'hF0;

  // ==========================================================
  // reset values; all but RST_ZERO and RST_PC differ from zero
  localparam logic [7:0]  RST_PORT    = 8'hFF;
  localparam logic [7:0]  RST_SP      = 8'h07;
  localparam logic [7:0]  RST_STRETCH = 8'h01;
  localparam logic [7:0]  RST_S0RLL   = 8'hD9;
  localparam logic [7:0]  RST_RLH     = 8'h03;
  localparam logic [7:0]  RST_ZERO    = 8'h00;
  localparam logic [15:0] RST_PC      = 16'h0000;

  // ==========================================================
  // field positions
  localparam int PSW_CARRY   = 7;
  localparam int PSW_AUXC    = 6;
  localparam int PSW_USER0   = 5;
  localparam int PSW_BANK_HI = 4;
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_OVF     = 2;
  localparam int PSW_USER1   = 1;
  localparam int PSW_PARITY  = 0;
  localparam int BAUD_SRC    = 7;
  localparam int PSEL_BIT    = 0;
  localparam int CFG_PORT_EN = 5;
  localparam logic [15:0] CFG_PORT_ADDR = 16'h270C;
  localparam int NUM_PINS    = 15;

endpackage : msfr_pkg

/* rtl/msfr_bank.sv */
/*
  Core special function register bank with digital I/O port
  registers for pins 0 to 14, stack pointer and program counter.
  Assumes the core issues one register access per cycle on clk_in
  and drives the fetch/push strobes synchronously; pin inputs are
  asynchronous and are synchronised here.
*/
// What this block does
// RULE_01 - stack pointer reads 0x07 after reset
// RULE_02 - stack pointer increments before push or call stores data
// RULE_03 - 16-bit program counter, 0 at reset, counts fetches and operands
// RULE_04 - bank select bits 4:3 pick working register block base
// RULE_05 - status word holds carry, aux carry, user, overflow flags
// RULE_06 - status bit 0 gives even parity with accumulator
// RULE_07 - two 16-bit data pointers written as low and high bytes
// RULE_08 - port register: direction in upper nibble, data in lower
// RULE_09 - direction 1 makes pin output, 0 makes it input
// RULE_10 - output pin drives its data bit level
// RULE_11 - port read returns actual pin state
// RULE_12 - pins start as outputs, high impedance until port enable set
// RULE_13 - firmware sets direction and data before enabling ports
// RULE_14 - operand register serves multiply, divide and scratch
// RULE_15 - baud control register keeps only bit 7
// RULE_16 - paged register gives high address byte for paged moves
// RULE_17 - polarity register for external interrupts two and three
// RULE_18 - select bit picks pointer without altering either value
// RULE_19 - unmapped reads undefined, unmapped writes ignored
`timescale 1ns/1ns
module msfr_bank
  import msfr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // register port
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic      [7:0]  sfr_rdata_out,
  // core sequencing strobes
  input  wire logic        fetch_in,
  input  wire logic        push_in,
  input  wire logic        pop_in,
  input  wire logic        pc_load_in,
  input  wire logic [15:0] pc_load_val_in,
  // flag and multiply/divide result updates from the core
  input  wire logic        alu_flags_we_in,
  input  wire logic [3:0]  alu_flags_in,
  input  wire logic        mul_div_we_in,
  input  wire logic [7:0]  acc_result_in,
  input  wire logic [7:0]  mdop_result_in,
  // configuration port enable bit write
  input  wire logic        cfg_wr_in,
  input  wire logic [15:0] cfg_addr_in,
  input  wire logic [7:0]  cfg_wdata_in,
  // core views
  output logic [15:0] program_counter_out,
  output logic [7:0]  stack_pointer_out,
  output logic [7:0]  push_addr_out,
  output logic [4:0]  bank_base_out,
  output logic [15:0] active_pointer_out,
  output logic [7:0]  paged_address_high_out,
  output logic [1:0]  ext_int_polarity_out,
  output logic        baud_source_out,
  output logic [7:0]  mdop_out,
  output logic [2:0]  stretch_out,
  // pins
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic      [NUM_PINS-1:0] pin_out,
  output logic      [NUM_PINS-1:0] pin_oe_out
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]  port0, port1, port2, port3;
    logic [7:0]  sp, dpl0, dph0, data_pointer_low_second, data_pointer_high_second, psel;
    logic [7:0]  uartspd, tctl, tmode, tl0, tl1, th0, th1, stretch;
    logic [7:0]  s0ctl, serial_zero_buffer, interrupt_enable_two, s1ctl, serial_one_buffer, s1rll;
    logic [7:0]  interrupt_enable_zero, ip0, s0rll, interrupt_enable_one, ip1, s0rlh, s1rlh;
    logic [7:0]  pagehi, irqctl, extpol, program_status_word, baud, acc, mdop;
    logic        port_en;
    logic [15:0] pc;
    logic [NUM_PINS-1:0] sync1, sync2;
    logic [7:0]  rdata;
    logic [NUM_PINS-1:0] pout, poe;
    logic [7:0]  push_addr;
    logic [15:0] aptr;
  } msfr_state_type;

  msfr_state_type st_ff;
  msfr_state_type nxt_st;
  logic [NUM_PINS-1:0] dir_bits;
  logic [NUM_PINS-1:0] data_bits;
  logic                parity;

  // ==========================================================
  // port nibbles gathered into pin vectors
  // pin 14 sits one short of a full nibble in the last group
  assign dir_bits  = {st_ff.port3[6:4], st_ff.port2[7:4],
                      st_ff.port1[7:4], st_ff.port0[7:4]};   // RULE_08
  assign data_bits = {st_ff.port3[2:0], st_ff.port2[3:0],
                      st_ff.port1[3:0], st_ff.port0[3:0]};   // RULE_08
  assign parity    = ^st_ff.acc;                             // RULE_06

  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    // two-flop synchroniser, only sync2 is read
    nxt_st.sync1 = pin_in;
    nxt_st.sync2 = st_ff.sync1;
    // program counter
    if (pc_load_in) begin
      nxt_st.pc = pc_load_val_in;
    end else if (fetch_in) begin
      nxt_st.pc = st_ff.pc + 16'h0001;                       // RULE_03
    end
    // stack: pre-increment so the first push lands one above
    if (push_in) begin
      nxt_st.sp = st_ff.sp + 8'h01;                          // RULE_02
    end else if (pop_in) begin
      nxt_st.sp = st_ff.sp - 8'h01;
    end
    if (alu_flags_we_in) begin
      nxt_st.program_status_word[PSW_CARRY] = alu_flags_in[3];               // RULE_05
      nxt_st.program_status_word[PSW_AUXC]  = alu_flags_in[2];               // RULE_05
      nxt_st.program_status_word[PSW_OVF]   = alu_flags_in[1];               // RULE_05
    end
    if (mul_div_we_in) begin
      nxt_st.acc  = acc_result_in;
      nxt_st.mdop = mdop_result_in;                          // RULE_14
    end
    // configuration port enable
    if (cfg_wr_in && cfg_addr_in == CFG_PORT_ADDR) begin
      nxt_st.port_en = cfg_wdata_in[CFG_PORT_EN];            // RULE_12
    end
    // software writes win over core updates in the same cycle
    if (sfr_wr_in) begin
      case (sfr_addr_in)
        OFS_PORT0:   nxt_st.port0   = sfr_wdata_in;          // RULE_08
        OFS_PORT1:   nxt_st.port1   = sfr_wdata_in;
        OFS_PORT2:   nxt_st.port2   = sfr_wdata_in;
        OFS_PORT3:   nxt_st.port3   = sfr_wdata_in;
        OFS_SP:      nxt_st.sp      = sfr_wdata_in;
        OFS_DPL0:    nxt_st.dpl0    = sfr_wdata_in;          // RULE_07
        OFS_DPH0:    nxt_st.dph0    = sfr_wdata_in;          // RULE_07
        OFS_DATA_POINTER_LOW_SECOND:    nxt_st.data_pointer_low_second    = sfr_wdata_in;          // RULE_07
        OFS_DATA_POINTER_HIGH_SECOND:    nxt_st.data_pointer_high_second    = sfr_wdata_in;          // RULE_07
        OFS_UARTSPD: nxt_st.uartspd = sfr_wdata_in;
        OFS_TCTL:    nxt_st.tctl    = sfr_wdata_in;
        OFS_TMODE:   nxt_st.tmode   = sfr_wdata_in;
        OFS_TL0:     nxt_st.tl0     = sfr_wdata_in;
        OFS_TL1:     nxt_st.tl1     = sfr_wdata_in;
        OFS_TH0:     nxt_st.th0     = sfr_wdata_in;
        OFS_TH1:     nxt_st.th1     = sfr_wdata_in;
        OFS_STRETCH: nxt_st.stretch = sfr_wdata_in;
        OFS_PSEL:    nxt_st.psel    = sfr_wdata_in;          // RULE_18
        OFS_S0CTL:   nxt_st.s0ctl   = sfr_wdata_in;
        OFS_SERIAL_ZERO_BUFFER:   nxt_st.serial_zero_buffer   = sfr_wdata_in;
        OFS_INTERRUPT_ENABLE_TWO:    nxt_st.interrupt_enable_two    = sfr_wdata_in;
        OFS_S1CTL:   nxt_st.s1ctl   = sfr_wdata_in;
        OFS_SERIAL_ONE_BUFFER:   nxt_st.serial_one_buffer   = sfr_wdata_in;
        OFS_S1RLL:   nxt_st.s1rll   = sfr_wdata_in;
        OFS_INTERRUPT_ENABLE_ZERO:    nxt_st.interrupt_enable_zero    = sfr_wdata_in;
        OFS_IP0:     nxt_st.ip0     = sfr_wdata_in;
        OFS_S0RLL:   nxt_st.s0rll   = sfr_wdata_in;
        OFS_INTERRUPT_ENABLE_ONE:    nxt_st.interrupt_enable_one    = sfr_wdata_in;
        OFS_IP1:     nxt_st.ip1     = sfr_wdata_in;
        OFS_S0RLH:   nxt_st.s0rlh   = sfr_wdata_in;
        OFS_S1RLH:   nxt_st.s1rlh   = sfr_wdata_in;
        OFS_PAGEHI:  nxt_st.pagehi  = sfr_wdata_in;          // RULE_16
        OFS_IRQCTL:  nxt_st.irqctl  = sfr_wdata_in;
        OFS_EXTPOL:  nxt_st.extpol  = sfr_wdata_in;          // RULE_17
        OFS_PSW:     nxt_st.program_status_word     = sfr_wdata_in;          // RULE_04
        OFS_BAUD:    nxt_st.baud    = {sfr_wdata_in[BAUD_SRC],
                                       7'h00};               // RULE_15
        OFS_ACC:     nxt_st.acc     = sfr_wdata_in;
        OFS_MDOP:    nxt_st.mdop    = sfr_wdata_in;          // RULE_14
        default:     nxt_st.rdata   = st_ff.rdata;           // RULE_19
      endcase
    end
    // parity bit follows the accumulator, never software
    nxt_st.program_status_word[PSW_PARITY] = ^nxt_st.acc;                    // RULE_06
    // read mux: ports show the synchronised pins
    if (sfr_rd_in) begin
      case (sfr_addr_in)
        OFS_PORT0:   nxt_st.rdata = {st_ff.port0[7:4],
                                     st_ff.sync2[3:0]};      // RULE_11
        OFS_PORT1:   nxt_st.rdata = {st_ff.port1[7:4],
                                     st_ff.sync2[7:4]};      // RULE_11
        OFS_PORT2:   nxt_st.rdata = {st_ff.port2[7:4],
                                     st_ff.sync2[11:8]};     // RULE_11
        OFS_PORT3:   nxt_st.rdata = {st_ff.port3[7:4], 1'b0,
                                     st_ff.sync2[14:12]};    // RULE_11
        OFS_SP:      nxt_st.rdata = st_ff.sp;
        OFS_DPL0:    nxt_st.rdata = st_ff.dpl0;
        OFS_DPH0:    nxt_st.rdata = st_ff.dph0;
        OFS_DATA_POINTER_LOW_SECOND:    nxt_st.rdata = st_ff.data_pointer_low_second;
        OFS_DATA_POINTER_HIGH_SECOND:    nxt_st.rdata = st_ff.data_pointer_high_second;
        OFS_UARTSPD: nxt_st.rdata = st_ff.uartspd;
        OFS_TCTL:    nxt_st.rdata = st_ff.tctl;
        OFS_TMODE:   nxt_st.rdata = st_ff.tmode;
        OFS_TL0:     nxt_st.rdata = st_ff.tl0;
        OFS_TL1:     nxt_st.rdata = st_ff.tl1;
        OFS_TH0:     nxt_st.rdata = st_ff.th0;
        OFS_TH1:     nxt_st.rdata = st_ff.th1;
        OFS_STRETCH: nxt_st.rdata = st_ff.stretch;
        OFS_PSEL:    nxt_st.rdata = st_ff.psel;
        OFS_S0CTL:   nxt_st.rdata = st_ff.s0ctl;
        OFS_SERIAL_ZERO_BUFFER:   nxt_st.rdata = st_ff.serial_zero_buffer;
        OFS_INTERRUPT_ENABLE_TWO:    nxt_st.rdata = st_ff.interrupt_enable_two;
        OFS_S1CTL:   nxt_st.rdata = st_ff.s1ctl;
        OFS_SERIAL_ONE_BUFFER:   nxt_st.rdata = st_ff.serial_one_buffer;
        OFS_S1RLL:   nxt_st.rdata = st_ff.s1rll;
        OFS_INTERRUPT_ENABLE_ZERO:    nxt_st.rdata = st_ff.interrupt_enable_zero;
        OFS_IP0:     nxt_st.rdata = st_ff.ip0;
        OFS_S0RLL:   nxt_st.rdata = st_ff.s0rll;
        OFS_INTERRUPT_ENABLE_ONE:    nxt_st.rdata = st_ff.interrupt_enable_one;
        OFS_IP1:     nxt_st.rdata = st_ff.ip1;
        OFS_S0RLH:   nxt_st.rdata = st_ff.s0rlh;
        OFS_S1RLH:   nxt_st.rdata = st_ff.s1rlh;
        OFS_PAGEHI:  nxt_st.rdata = st_ff.pagehi;
        OFS_IRQCTL:  nxt_st.rdata = st_ff.irqctl;
        OFS_EXTPOL:  nxt_st.rdata = st_ff.extpol;
        OFS_PSW:     nxt_st.rdata = {st_ff.program_status_word[7:1], parity};
        OFS_BAUD:    nxt_st.rdata = st_ff.baud;
        OFS_ACC:     nxt_st.rdata = st_ff.acc;
        OFS_MDOP:    nxt_st.rdata = st_ff.mdop;
        // undefined data; zero is one legal choice
        default:     nxt_st.rdata = RST_ZERO;                // RULE_19
      endcase
    end
    // pin drivers: gated by the port enable so the pins stay
    // floating until firmware has set direction and data
    nxt_st.pout = data_bits;                                 // RULE_10
    nxt_st.poe  = nxt_st.port_en ? dir_bits : '0;            // RULE_09 RULE_12
    // core views registered so every output comes from a flop;
    // built from the next state, so they show no extra lag
    nxt_st.push_addr = nxt_st.sp + 8'h01;                    // RULE_02
    nxt_st.aptr      = nxt_st.psel[PSEL_BIT] ?
                       {nxt_st.data_pointer_high_second, nxt_st.data_pointer_low_second} :
                       {nxt_st.dph0, nxt_st.dpl0};           // RULE_18
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff         <= '0;
      st_ff.port0   <= RST_PORT;                             // RULE_12
      st_ff.port1   <= RST_PORT;
      st_ff.port2   <= RST_PORT;
      st_ff.port3   <= RST_PORT;
      st_ff.sp      <= RST_SP;                               // RULE_01
      st_ff.pc      <= RST_PC;                               // RULE_03
      st_ff.stretch <= RST_STRETCH;
      st_ff.s0rll   <= RST_S0RLL;
      st_ff.s0rlh   <= RST_RLH;
      st_ff.s1rlh   <= RST_RLH;
      st_ff.push_addr <= RST_SP + 8'h01;                     // RULE_02
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign sfr_rdata_out          = st_ff.rdata;
  assign program_counter_out    = st_ff.pc;
  assign stack_pointer_out      = st_ff.sp;
  assign push_addr_out          = st_ff.push_addr;           // RULE_02
  assign bank_base_out          = {st_ff.program_status_word[PSW_BANK_HI],
                                   st_ff.program_status_word[PSW_BANK_LO],
                                   3'b000};                  // RULE_04
  assign active_pointer_out     = st_ff.aptr;                // RULE_18
  assign paged_address_high_out = st_ff.pagehi;              // RULE_16
  assign ext_int_polarity_out   = st_ff.extpol[1:0];         // RULE_17
  assign baud_source_out        = st_ff.baud[BAUD_SRC];      // RULE_15
  assign mdop_out               = st_ff.mdop;                // RULE_14
  assign stretch_out            = st_ff.stretch[2:0];
  assign pin_out                = st_ff.pout;
  assign pin_oe_out             = st_ff.poe;

  // ==========================================================
  // checks
  property p_sp_reset;
    @(posedge clk_in) $rose(reset_n_in) |-> stack_pointer_out == RST_SP;
  endproperty
  a_sp_reset: assert property (p_sp_reset)  // RULE_01
    else $error("stack pointer not 0x07 after reset");

  property p_push_inc;
    @(posedge clk_in) disable iff (!reset_n_in)
      push_in && !sfr_wr_in |=> stack_pointer_out == $past(stack_pointer_out) + 8'h01;
  endproperty
  a_push_inc: assert property (p_push_inc)  // RULE_02
    else $error("push did not increment stack pointer");

  property p_pc_inc;
    @(posedge clk_in) disable iff (!reset_n_in)
      fetch_in && !pc_load_in |=>
        program_counter_out == $past(program_counter_out) + 16'h0001;
  endproperty
  a_pc_inc: assert property (p_pc_inc)  // RULE_03
    else $error("program counter did not step on fetch");

  property p_bank;
    @(posedge clk_in) disable iff (!reset_n_in)
      sfr_wr_in && sfr_addr_in == OFS_PSW |=>
        bank_base_out == {$past(sfr_wdata_in[4:3]), 3'b000};
  endproperty
  a_bank: assert property (p_bank)  // RULE_04
    else $error("bank base mismatch");

  property p_parity;
    @(posedge clk_in) disable iff (!reset_n_in)
      ^{st_ff.acc, st_ff.program_status_word[PSW_PARITY]} == 1'b0;
  endproperty
  a_parity: assert property (p_parity)  // RULE_06
    else $error("parity flag not even");

  property p_psel_keep;
    @(posedge clk_in) disable iff (!reset_n_in)
      sfr_wr_in && sfr_addr_in == OFS_PSEL |=>
        {st_ff.dph0, st_ff.dpl0, st_ff.data_pointer_high_second, st_ff.data_pointer_low_second} ==
        $past({st_ff.dph0, st_ff.dpl0, st_ff.data_pointer_high_second, st_ff.data_pointer_low_second});
  endproperty
  a_psel_keep: assert property (p_psel_keep)  // RULE_18
    else $error("pointer changed on select write");

  property p_hiz;
    @(posedge clk_in) disable iff (!reset_n_in)
      !st_ff.port_en |-> pin_oe_out == '0;
  endproperty
  a_hiz: assert property (p_hiz)  // RULE_12
    else $error("pin driven while ports disabled");

  property p_baud;
    @(posedge clk_in) disable iff (!reset_n_in)
      st_ff.baud[6:0] == 7'h00;
  endproperty
  a_baud: assert property (p_baud)  // RULE_15
    else $error("unused baud bits set");

  property p_pin_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      sfr_rd_in && sfr_addr_in == OFS_PORT0 |=>
        sfr_rdata_out[3:0] == $past(st_ff.sync2[3:0]);
  endproperty
  a_pin_read: assert property (p_pin_read)  // RULE_11
    else $error("port read not pin state");

  // enabling the drivers must expose exactly the direction latch
  sequence s_port_enable_write;
    cfg_wr_in && cfg_addr_in == CFG_PORT_ADDR && cfg_wdata_in[CFG_PORT_EN];
  endsequence

  property p_oe_follows_dir;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_port_enable_write |=> pin_oe_out == $past(dir_bits);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir)  // RULE_09
    else $error("drivers do not follow direction bits");

  property p_pin_level;
    @(posedge clk_in) disable iff (!reset_n_in)
      1'b1 |=> pin_out == $past(data_bits);
  endproperty
  a_pin_level: assert property (p_pin_level)  // RULE_10
    else $error("pin level does not follow data bit");

  property p_push_addr;
    @(posedge clk_in) disable iff (!reset_n_in)
      push_addr_out == stack_pointer_out + 8'h01;
  endproperty
  a_push_addr: assert property (p_push_addr)  // RULE_02
    else $error("push address not one above stack pointer");

endmodule // msfr_bank

/* tb/msfr_bank_tb.sv */
/*
  Self-checking bench for the core register bank and port block.
  Assumes msfr_pkg is compiled first and msfr_bank carries its own
  assertions; the bench drives every port itself.
*/
`timescale 1ns/1ns
module msfr_bank_tb;
  import msfr_pkg::*;
  // ==========================================================
  // stimulus and observation signals
  logic        clk_in = 1'b0;
  logic        reset_n_in, sfr_wr_in, sfr_rd_in, fetch_in, push_in, pop_in;
  logic        pc_load_in, alu_flags_we_in, mul_div_we_in, cfg_wr_in;
  logic        baud_source_out;
  logic [7:0]  sfr_addr_in, sfr_wdata_in, sfr_rdata_out, acc_result_in;
  logic [7:0]  mdop_result_in, cfg_wdata_in, stack_pointer_out, mdop_out;
  logic [7:0]  push_addr_out, paged_address_high_out, d, pw, ac;
  logic [15:0] pc_load_val_in, cfg_addr_in, program_counter_out;
  logic [15:0] active_pointer_out;
  logic [3:0]  alu_flags_in;
  logic [4:0]  bank_base_out;
  logic [1:0]  ext_int_polarity_out;
  logic [2:0]  stretch_out;
  logic [14:0] pin_in, pin_out, pin_oe_out;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // address and reset value of every plain register
  localparam logic [15:0] RV [34] = '{
    16'h8107, 16'h8200, 16'h8300, 16'h8400, 16'h8500, 16'h8700, 16'h8800,
    16'h8900, 16'h8A00, 16'h8B00, 16'h8C00, 16'h8D00, 16'h8E01, 16'h9200,
    16'h9800, 16'h9900, 16'h9A00, 16'h9B00, 16'h9C00, 16'h9D00, 16'hA800,
    16'hA900, 16'hAAD9, 16'hB800, 16'hB900, 16'hBA03, 16'hBB03, 16'hBF00,
    16'hC000, 16'hC800, 16'hD000, 16'hD800, 16'hE000, 16'hF000};

  always #2 clk_in = ~clk_in;

  msfr_bank i_msfr_bank (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .fetch_in(fetch_in), .push_in(push_in), .pop_in(pop_in),
    .pc_load_in(pc_load_in), .pc_load_val_in(pc_load_val_in),
    .alu_flags_we_in(alu_flags_we_in), .alu_flags_in(alu_flags_in),
    .mul_div_we_in(mul_div_we_in), .acc_result_in(acc_result_in),
    .mdop_result_in(mdop_result_in), .cfg_wr_in(cfg_wr_in),
    .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in),
    .program_counter_out(program_counter_out),
    .stack_pointer_out(stack_pointer_out),
    .push_addr_out(push_addr_out), .bank_base_out(bank_base_out),
    .active_pointer_out(active_pointer_out),
    .paged_address_high_out(paged_address_high_out),
    .ext_int_polarity_out(ext_int_polarity_out),
    .baud_source_out(baud_source_out), .mdop_out(mdop_out),
    .stretch_out(stretch_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out)
  );

  // ==========================================================
  // access tasks; each starts and ends 1 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr_in = a;
    sfr_wdata_in = v;
    sfr_wr_in = 1'b1;
    step(1);
    sfr_wr_in = 1'b0;
    // idle cycle so a following call never re-raises the strobe at once
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    step(1);
    sfr_rd_in = 1'b0;
    v = sfr_rdata_out;
    step(1);
  endtask
  task automatic cfg(input logic [15:0] a, input logic [7:0] v);
    cfg_addr_in = a;
    cfg_wdata_in = v;
    cfg_wr_in = 1'b1;
    step(1);
    cfg_wr_in = 1'b0;
    step(1);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {sfr_wr_in, sfr_rd_in, fetch_in, push_in, pop_in, pc_load_in} = '0;
    {alu_flags_we_in, mul_div_we_in, cfg_wr_in} = '0;
    {sfr_addr_in, sfr_wdata_in, acc_result_in, mdop_result_in} = '0;
    {cfg_wdata_in, pc_load_val_in, cfg_addr_in, alu_flags_in} = '0;
    pin_in = 15'h2C35;
    reset_n_in = 1'b0;
    step(20);
    reset_n_in = 1'b1;
    // reset values of plain registers, ports and core views
    foreach (RV[k]) begin
      rd(RV[k][15:8], d);
      chk(d, RV[k][7:0]);
    end
    rd(OFS_PORT0, d);
    chk(d, {4'hF, pin_in[3:0]});
    rd(OFS_PORT1, d);
    chk(d, {4'hF, pin_in[7:4]});
    rd(OFS_PORT2, d);
    chk(d, {4'hF, pin_in[11:8]});
    rd(OFS_PORT3, d);
    chk(d, {4'hF, 1'b0, pin_in[14:12]});
    chk(program_counter_out, 16'h0000);
    chk(pin_oe_out, 15'h0000);
    chk(stretch_out, 3'h1);
    // stack grows upward, pre-incremented
    chk(push_addr_out, 8'h08);
    push_in = 1'b1;
    step(1);
    chk(stack_pointer_out, 8'h08);
    pop_in = 1'b1;
    step(1);
    chk(stack_pointer_out, 8'h09);
    push_in = 1'b0;
    step(1);
    pop_in = 1'b0;
    chk(stack_pointer_out, 8'h08);
    // fetch counting, load priority and 16-bit wrap
    fetch_in = 1'b1;
    step(3);
    chk(program_counter_out, 16'h0003);
    pc_load_in = 1'b1;
    pc_load_val_in = 16'hFFFF;
    step(1);
    pc_load_in = 1'b0;
    chk(program_counter_out, 16'hFFFF);
    step(1);
    fetch_in = 1'b0;
    chk(program_counter_out, 16'h0000);
    // write and read back every plain register except PSW and BAUD
    foreach (RV[k]) begin
      if (RV[k][15:8] != OFS_PSW && RV[k][15:8] != OFS_BAUD) begin
        wr(RV[k][15:8], RV[k][15:8] ^ 8'h5A);
        rd(RV[k][15:8], d);
        chk(d, RV[k][15:8] ^ 8'h5A);
      end
    end
    // status word layout, bank bases and hardware parity
    for (int i = 0; i < 4; i++) begin
      ac = 8'(8'h13 * (i + 1));
      pw = 8'hA7 | 8'(i << 3);
      wr(OFS_ACC, ac);
      wr(OFS_PSW, pw);
      chk(bank_base_out, {i[1:0], 3'b000});
      rd(OFS_PSW, d);
      chk(d, {pw[7:1], ^ac});
    end
    alu_flags_in = 4'b1010;
    alu_flags_we_in = 1'b1;
    step(1);
    alu_flags_we_in = 1'b0;
    rd(OFS_PSW, d);
    chk(d, {2'b10, pw[5:3], 1'b1, pw[1], ^ac});
    acc_result_in = 8'h97;
    mdop_result_in = 8'h3C;
    mul_div_we_in = 1'b1;
    step(1);
    mul_div_we_in = 1'b0;
    chk(mdop_out, 8'h3C);
    rd(OFS_PSW, d);
    chk(d[0], 1'b1);
    // dual data pointers and select bit
    wr(OFS_PSEL, 8'h00);
    wr(OFS_DPL0, 8'h11);
    wr(OFS_DPH0, 8'h22);
    wr(OFS_DATA_POINTER_HIGH_SECOND, 8'h44);
    wr(OFS_DATA_POINTER_LOW_SECOND, 8'h33);
    chk(active_pointer_out, 16'h2211);
    wr(OFS_PSEL, 8'h01);
    chk(active_pointer_out, 16'h4433);
    rd(OFS_DPL0, d);
    chk(d, 8'h11);
    wr(OFS_PSEL, 8'h00);
    chk(active_pointer_out, 16'h2211);
    // side registers feeding core views
    wr(OFS_PAGEHI, 8'hC3);
    chk(paged_address_high_out, 8'hC3);
    wr(OFS_EXTPOL, 8'h02);
    chk(ext_int_polarity_out, 2'b10);
    wr(OFS_BAUD, 8'h80);
    chk(baud_source_out, 1'b1);
    wr(OFS_BAUD, 8'h7F);
    chk(baud_source_out, 1'b0);
    wr(OFS_STRETCH, 8'h07);
    chk(stretch_out, 3'h7);
    // unmapped place: write ignored, read returns zero
    wr(8'h86, 8'h55);
    rd(8'h86, d);
    chk(d, 8'h00);
    // ports: configure first, then enable the drivers
    for (int k = 0; k < 4; k++) begin
      wr(8'h80 + 8'(k << 4), 8'hFF);
    end
    wr(OFS_PORT0, 8'hA5);
    step(1);
    chk(pin_out, 15'h7FF5);
    chk(pin_oe_out, 15'h0000);
    cfg(CFG_PORT_ADDR, 8'h20);
    step(1);
    chk(pin_oe_out, 15'h7FFA);
    pin_in = 15'h5A4A;
    step(3);
    rd(OFS_PORT0, d);
    chk(d, 8'hAA);
    cfg(CFG_PORT_ADDR, 8'h00);
    step(1);
    chk(pin_oe_out, 15'h0000);
    // second reset in mid-run
    reset_n_in = 1'b0;
    step(1);
    reset_n_in = 1'b1;
    rd(OFS_SP, d);
    chk(d, 8'h07);
    tally_and_finish();
  end
endmodule // msfr_bank_tb
